/* verilog/vsl_params.svh */
// Purpose: constants for the sync and luminance control registers
// Assumes: 8-bit registers at subaddresses 0x08 and 0x09
// Notes: bit positions and reset values used by vsl_ctrl
// Contract
// - auto bit set: device picks field standard
// - select bit: 0=50Hz/625, 1=60Hz/525, manual only
// - forced toggle makes parity flip every field
// - time constant 00 TV, 01 VTR, 11 fast
// - loop bit 1 opens horizontal PLL
// - noise field: normal, fast, free run, bypass
// - bypass bit disables trap/comb filter
// - comb bit picks comb over trap
// - extra delay: one NTSC, two PAL lines
// - bandwidth bit selects wide notch, less luma
// - codes 1-7: peaking 8.0 to 1.6 dB
// - 0 plain, 8-15 low-pass, top three notch
`ifndef VSL_PARAMS_SVH
`define VSL_PARAMS_SVH

`define VSL_ADDR_SYNC 8'h08
`define VSL_ADDR_LUMA 8'h09

`define VSL_SYNC_RESET 8'h98
`define VSL_LUMA_RESET 8'h00

`define VSL_B_AUTO_FIELD 7
`define VSL_B_FIELD_SEL 6
`define VSL_B_FORCED_TGL 5
`define VSL_F_HTC_HI 4
`define VSL_F_HTC_LO 3
`define VSL_B_HLOOP_OPEN 2
`define VSL_F_VNOI_HI 1
`define VSL_F_VNOI_LO 0

`define VSL_B_BYPASS 7
`define VSL_B_COMB_EN 6
`define VSL_B_EXTRA_DEL 5
`define VSL_B_REMOD_BW 4
`define VSL_F_SHARP_HI 3
`define VSL_F_SHARP_LO 0

`define VSL_LINES_50HZ 10'h271
`define VSL_LINES_60HZ 10'h20d
`define VSL_DELAY_NTSC 2'h1
`define VSL_DELAY_PAL 2'h2
`define VSL_DELAY_NONE 2'h0

`define VSL_SHARP_PLAIN 4'h0
`define VSL_SHARP_LP_MIN 4'h8
`define VSL_SHARP_NOTCH_MIN 4'hd

// peaking gains in tenths of a dB, all at 4.1 MHz
`define VSL_PEAK_1 7'h50
`define VSL_PEAK_2 7'h44
`define VSL_PEAK_3 7'h33
`define VSL_PEAK_4 7'h29
`define VSL_PEAK_5 7'h1e
`define VSL_PEAK_6 7'h17
`define VSL_PEAK_7 7'h10
`define VSL_PEAK_NONE 7'h00

`endif

/* verilog/vsl_pkg.sv */
// Purpose: types for the video sync and luminance control block
// Assumes: nothing beyond the params header
// Notes: enums drive the decoded mode outputs
package vsl_pkg;

	typedef enum logic [1:0] {
		VSL_HTC_TV = 2'b00,
		VSL_HTC_VTR = 2'b01,
		VSL_HTC_RSVD = 2'b10,
		VSL_HTC_FAST = 2'b11
	} vsl_htc_t;

	typedef enum logic [1:0] {
		VSL_VNR_NORMAL = 2'b00,
		VSL_VNR_FAST = 2'b01,
		VSL_VNR_FREE = 2'b10,
		VSL_VNR_BYPASS = 2'b11
	} vsl_vnr_t;

	typedef enum logic [1:0] {
		VSL_LUMA_TRAP = 2'b00,
		VSL_LUMA_COMB = 2'b01,
		VSL_LUMA_BYPASS = 2'b10
	} vsl_luma_t;

endpackage

/* verilog/vsl_ctrl.sv */
// Purpose: sync and luminance control registers with decoded controls
// Assumes: register port and status inputs come from logic on clock_i
// Notes: read data is registered, valid one cycle after rd_en_i
`timescale 1ns/1ps
`include "vsl_params.svh"

module vsl_ctrl (
	input wire logic clock_i, // 40 MHz line-locked clock
	input wire logic rst_n_i, // async reset, active low
	input wire logic wr_en_i, // register write strobe
	input wire logic rd_en_i, // register read strobe
	input wire logic [7:0] subaddr_i, // register subaddress
	input wire logic [7:0] wr_data_i, // write data
	output logic [7:0] rd_data_o, // read data
	output logic rd_valid_o, // read data valid pulse
	input wire logic detected_60hz_i, // detector: 60 Hz source seen
	input wire logic source_interlaced_i, // detector: source interlaced
	input wire logic field_start_i, // pulse at each field start
	input wire logic std_is_pal_i, // colour standard is PAL
	output logic field_60hz_o, // active field standard is 60 Hz
	output logic [9:0] lines_per_frame_o, // 625 or 525
	output logic field_parity_o, // odd/even field signal
	output vsl_pkg::vsl_htc_t htc_mode_o, // horizontal time constant
	output logic htc_reserved_o, // reserved time constant code
	output logic horiz_loop_open_o, // horizontal PLL opened
	output vsl_pkg::vsl_vnr_t vnr_mode_o, // vertical noise reduction
	output logic vnr_fast_conflict_o, // fast noise mode with auto on
	output vsl_pkg::vsl_luma_t luma_path_o, // trap, comb or bypass
	output logic [1:0] extra_delay_lines_o, // added delay in lines
	output logic wide_notch_o, // wide chroma notch selected
	output logic peaking_en_o, // sharpness peaking active
	output logic [6:0] peaking_gain_o, // peaking gain in 0.1 dB
	output logic lowpass_en_o, // sharpness low-pass active
	output logic [2:0] lowpass_level_o, // low-pass strength 0..7
	output logic lowpass_notch_o // low-pass with added notch
);

	// peaking gain table for the enhancement codes
	function automatic logic [6:0] peak_gain(input logic [3:0] code);
		logic [6:0] g;
		g = `VSL_PEAK_NONE;
		case (code)
			4'h1: g = `VSL_PEAK_1;
			4'h2: g = `VSL_PEAK_2;
			4'h3: g = `VSL_PEAK_3;
			4'h4: g = `VSL_PEAK_4;
			4'h5: g = `VSL_PEAK_5;
			4'h6: g = `VSL_PEAK_6;
			4'h7: g = `VSL_PEAK_7;
			default: g = `VSL_PEAK_NONE;
		endcase
		return g;
	endfunction

	function automatic logic is_lowpass(input logic [3:0] code);
		return code >= `VSL_SHARP_LP_MIN;
	endfunction

	function automatic logic is_peaking(input logic [3:0] code);
		return (code != `VSL_SHARP_PLAIN) && !is_lowpass(code);
	endfunction

	logic [7:0] sync_ff;
	logic [7:0] luma_ff;
	logic [7:0] rd_data_ff;
	logic rd_valid_ff;
	logic parity_ff;
	logic field_60hz_ff;
	logic [9:0] lines_ff;
	vsl_pkg::vsl_htc_t htc_ff;
	logic htc_rsvd_ff;
	logic hloop_ff;
	vsl_pkg::vsl_vnr_t vnr_ff;
	logic conflict_ff;
	vsl_pkg::vsl_luma_t luma_path_ff;
	logic [1:0] delay_ff;
	logic notch_ff;
	logic peak_en_ff;
	logic [6:0] peak_gain_ff;
	logic lp_en_ff;
	logic [2:0] lp_level_ff;
	logic lp_notch_ff;

	wire hit_sync = subaddr_i == `VSL_ADDR_SYNC;
	wire hit_luma = subaddr_i == `VSL_ADDR_LUMA;
	wire wr_sync = wr_en_i && hit_sync;
	wire wr_luma = wr_en_i && hit_luma;

	// register write, fields hold until rewritten
	wire [7:0] nxt_sync = wr_sync ? wr_data_i : sync_ff;
	wire [7:0] nxt_luma = wr_luma ? wr_data_i : luma_ff;

	// readback, unmapped subaddresses read zero
	wire [7:0] rd_sel = hit_sync ? sync_ff :
		(hit_luma ? luma_ff : 8'h00);
	wire [7:0] nxt_rd_data = rd_en_i ? rd_sel : rd_data_ff;

	wire auto_field = sync_ff[`VSL_B_AUTO_FIELD];
	wire field_sel = sync_ff[`VSL_B_FIELD_SEL];
	wire forced_tgl = sync_ff[`VSL_B_FORCED_TGL];
	wire [1:0] htc_code = sync_ff[`VSL_F_HTC_HI:`VSL_F_HTC_LO];
	wire hloop_open = sync_ff[`VSL_B_HLOOP_OPEN];
	wire [1:0] vnr_code = sync_ff[`VSL_F_VNOI_HI:`VSL_F_VNOI_LO];

	wire bypass = luma_ff[`VSL_B_BYPASS];
	wire comb_en = luma_ff[`VSL_B_COMB_EN];
	wire extra_del = luma_ff[`VSL_B_EXTRA_DEL];
	wire remod_bw = luma_ff[`VSL_B_REMOD_BW];
	wire [3:0] sharp = luma_ff[`VSL_F_SHARP_HI:`VSL_F_SHARP_LO];

	// field standard: detector in auto, select bit in manual
	wire nxt_field_60hz = auto_field ? detected_60hz_i : field_sel;
	wire [9:0] nxt_lines = nxt_field_60hz ?
		`VSL_LINES_60HZ : `VSL_LINES_50HZ;

	// parity flips per field for interlaced or forced
	wire tgl_now = field_start_i && (source_interlaced_i || forced_tgl);
	wire nxt_parity = tgl_now ? !parity_ff : parity_ff;

	wire [1:0] nxt_htc_code = htc_code;
	wire nxt_htc_rsvd = htc_code == 2'(vsl_pkg::VSL_HTC_RSVD);
	wire nxt_hloop = hloop_open;
	wire [1:0] nxt_vnr_code = vnr_code;
	// flags host misuse: fast noise mode while auto detect is on
	wire nxt_conflict = auto_field &&
		(vnr_code == 2'(vsl_pkg::VSL_VNR_FAST));

	// luma path: bypass wins, else comb or trap
	wire [1:0] nxt_luma_path = bypass ? 2'(vsl_pkg::VSL_LUMA_BYPASS) :
		(comb_en ? 2'(vsl_pkg::VSL_LUMA_COMB) :
		2'(vsl_pkg::VSL_LUMA_TRAP));

	// extra delay only applies outside comb operation
	wire comb_active = !bypass && comb_en;
	wire [1:0] std_delay = std_is_pal_i ? `VSL_DELAY_PAL : `VSL_DELAY_NTSC;
	wire [1:0] nxt_delay = (extra_del && !comb_active) ?
		std_delay : `VSL_DELAY_NONE;

	wire nxt_notch = remod_bw;

	wire nxt_peak_en = is_peaking(sharp);
	wire [6:0] nxt_peak_gain = peak_gain(sharp);
	wire nxt_lp_en = is_lowpass(sharp);
	wire [2:0] nxt_lp_level = nxt_lp_en ? sharp[2:0] : 3'h0;
	wire nxt_lp_notch = sharp >= `VSL_SHARP_NOTCH_MIN;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_ff <= `VSL_SYNC_RESET;
			luma_ff <= `VSL_LUMA_RESET;
			rd_data_ff <= 8'h00;
			rd_valid_ff <= 1'b0;
		end else begin
			sync_ff <= nxt_sync;
			luma_ff <= nxt_luma;
			rd_data_ff <= nxt_rd_data;
			rd_valid_ff <= rd_en_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			field_60hz_ff <= 1'b0;
			lines_ff <= `VSL_LINES_50HZ;
			parity_ff <= 1'b0;
			htc_ff <= vsl_pkg::VSL_HTC_FAST;
			htc_rsvd_ff <= 1'b0;
			hloop_ff <= 1'b0;
			vnr_ff <= vsl_pkg::VSL_VNR_NORMAL;
			conflict_ff <= 1'b0;
		end else begin
			field_60hz_ff <= nxt_field_60hz;
			lines_ff <= nxt_lines;
			parity_ff <= nxt_parity;
			htc_ff <= vsl_pkg::vsl_htc_t'(nxt_htc_code);
			htc_rsvd_ff <= nxt_htc_rsvd;
			hloop_ff <= nxt_hloop;
			vnr_ff <= vsl_pkg::vsl_vnr_t'(nxt_vnr_code);
			conflict_ff <= nxt_conflict;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			luma_path_ff <= vsl_pkg::VSL_LUMA_TRAP;
			delay_ff <= `VSL_DELAY_NONE;
			notch_ff <= 1'b0;
			peak_en_ff <= 1'b0;
			peak_gain_ff <= `VSL_PEAK_NONE;
			lp_en_ff <= 1'b0;
			lp_level_ff <= 3'h0;
			lp_notch_ff <= 1'b0;
		end else begin
			luma_path_ff <= vsl_pkg::vsl_luma_t'(nxt_luma_path);
			delay_ff <= nxt_delay;
			notch_ff <= nxt_notch;
			peak_en_ff <= nxt_peak_en;
			peak_gain_ff <= nxt_peak_gain;
			lp_en_ff <= nxt_lp_en;
			lp_level_ff <= nxt_lp_level;
			lp_notch_ff <= nxt_lp_notch;
		end
	end

	assign rd_data_o = rd_data_ff;
	assign rd_valid_o = rd_valid_ff;
	assign field_60hz_o = field_60hz_ff;
	assign lines_per_frame_o = lines_ff;
	assign field_parity_o = parity_ff;
	assign htc_mode_o = htc_ff;
	assign htc_reserved_o = htc_rsvd_ff;
	assign horiz_loop_open_o = hloop_ff;
	assign vnr_mode_o = vnr_ff;
	assign vnr_fast_conflict_o = conflict_ff;
	assign luma_path_o = luma_path_ff;
	assign extra_delay_lines_o = delay_ff;
	assign wide_notch_o = notch_ff;
	assign peaking_en_o = peak_en_ff;
	assign peaking_gain_o = peak_gain_ff;
	assign lowpass_en_o = lp_en_ff;
	assign lowpass_level_o = lp_level_ff;
	assign lowpass_notch_o = lp_notch_ff;

endmodule // vsl_ctrl

/* tb/vsl_ctrl_asserts.sv */
// Purpose: port checks for vsl_ctrl
// Assumes: decoded outputs land two edges after a write
// Notes: bound at file foot
`timescale 1ns/1ps
module vsl_ctrl_asserts (
	input logic clock_i, // clock
	input logic rst_n_i, // reset, active low
	input logic wr_en_i, // write strobe
	input logic rd_en_i, // read strobe
	input logic [7:0] subaddr_i, // subaddress
	input logic [7:0] wr_data_i, // write data
	input logic rd_valid_o, // read valid
	input logic detected_60hz_i, // 60 Hz seen
	input logic source_interlaced_i, // interlaced
	input logic field_start_i, // field pulse
	input logic std_is_pal_i, // pal source
	input logic field_60hz_o, // 60 Hz active
	input logic [9:0] lines_per_frame_o, // lines
	input logic field_parity_o, // parity
	input vsl_pkg::vsl_htc_t htc_mode_o, // time constant
	input logic htc_reserved_o, // reserved code
	input logic horiz_loop_open_o, // loop open
	input vsl_pkg::vsl_vnr_t vnr_mode_o, // noise mode
	input logic vnr_fast_conflict_o, // misuse flag
	input vsl_pkg::vsl_luma_t luma_path_o, // luma path
	input logic [1:0] extra_delay_lines_o, // delay
	input logic wide_notch_o, // wide notch
	input logic peaking_en_o, // peaking
	input logic lowpass_en_o, // low-pass
	input logic lowpass_notch_o // notch
);
	logic [7:0] q1, q2;
	logic s8, s9;
	assign s8 = wr_en_i && subaddr_i == 8'h08;
	assign s9 = wr_en_i && subaddr_i == 8'h09;
	// write data two edges back, lined up with decoded outputs
	always_ff @(posedge clock_i) begin
		q1 <= wr_data_i;
		q2 <= q1;
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	rd_answer_a: assert property (rd_en_i |=> rd_valid_o)
		else $error("read not answered");
	rd_single_a: assert property (!rd_en_i |=> !rd_valid_o)
		else $error("valid without read");
	std_lines_a: assert property (lines_per_frame_o ==
		(field_60hz_o ? 10'h20d : 10'h271)) else $error("line count off");
	field_std_a: assert property (s8 |=> ##1 field_60hz_o ==
		(q2[7] ? $past(detected_60hz_i) : q2[6])) else $error("standard off");
	time_const_a: assert property (s8 |=> ##1 htc_mode_o == q2[4:3] &&
		htc_reserved_o == (q2[4:3] == 2'b10)) else $error("time constant off");
	loop_noise_a: assert property (s8 |=> ##1 vnr_mode_o == q2[1:0] &&
		horiz_loop_open_o == q2[2]) else $error("loop or noise mode off");
	misuse_flag_a: assert property (s8 |=> ##1 vnr_fast_conflict_o ==
		(q2[7] && q2[1:0] == 2'b01)) else $error("misuse flag off");
	luma_path_a: assert property (s9 |=> ##1 wide_notch_o == q2[4] &&
		luma_path_o == (q2[7] ? 2'b10 : {1'b0, q2[6]})) else $error("luma off");
	sharp_sel_a: assert property (s9 |=> ##1 lowpass_en_o == q2[3] &&
		peaking_en_o == (!q2[3] && q2[2:0] != 3'h0) &&
		lowpass_notch_o == (q2[3:0] > 4'hc)) else $error("sharpness off");
	line_delay_a: assert property (s9 |=> ##1 extra_delay_lines_o ==
		(q2[5] && (q2[7] || !q2[6]) ? ($past(std_is_pal_i) ? 2'h2 : 2'h1) : 2'h0))
		else $error("extra delay off");
	parity_flip_a: assert property (field_start_i && source_interlaced_i |=>
		field_parity_o != $past(field_parity_o)) else $error("parity kept");
	parity_hold_a: assert property (!field_start_i |=> $stable(field_parity_o))
		else $error("parity moved");
endmodule // vsl_ctrl_asserts

bind vsl_ctrl vsl_ctrl_asserts i_chk (.*);

/* tb/vsl_host.sv */
// Purpose: host side of the register port
// Assumes: callers enter just after a rising edge
// Notes: write data lines inverted once a write strobe is done
`timescale 1ns/1ps
module vsl_host (
	input logic clock_i, // clock
	input logic rd_valid_i, // read valid
	input logic [7:0] rd_data_i, // read data
	output logic wr_en_o, // write strobe
	output logic rd_en_o, // read strobe
	output logic [7:0] subaddr_o, // subaddress
	output logic [7:0] wr_data_o // write data
);
	initial {wr_en_o, rd_en_o, subaddr_o, wr_data_o} = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		subaddr_o = a;
		wr_data_o = d;
		wr_en_o = 1'b1;
		@(posedge clock_i);
		#1;
		wr_en_o = 1'b0;
		wr_data_o = ~d;
		@(posedge clock_i);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		subaddr_o = a;
		rd_en_o = 1'b1;
		@(posedge clock_i);
		#1;
		rd_en_o = 1'b0;
		// answer stands for this cycle; take it settled
		d = rd_valid_i ? rd_data_i : 8'hxx;
		@(posedge clock_i);
		#1;
	endtask
endmodule // vsl_host

/* tb/vsl_ctrl_bench.sv */
// Purpose: self-checking bench for vsl_ctrl
// Assumes: host model drives the register port
// Notes: random data from an lfsr with fixed start
`timescale 1ns/1ps
module vsl_ctrl_bench;
	logic clock_i, rst_n_i, wr_en, rd_en, rd_valid, det60, inter, fstart;
	logic pal, parity, pk_en, lp_en;
	logic [7:0] subaddr, wr_data, rd_data, d, r;
	logic [6:0] gain;
	logic [2:0] lp_lvl;
	logic [31:0] lfsr = 32'h0000_7883;
	logic [6:0] gains [8] = '{7'h00, 7'h50, 7'h44, 7'h33, 7'h29, 7'h1e,
		7'h17, 7'h10};
	int failures = 0;
	int total_checks = 0;
	vsl_host i_host (.clock_i(clock_i), .rd_valid_i(rd_valid),
		.rd_data_i(rd_data), .wr_en_o(wr_en), .rd_en_o(rd_en),
		.subaddr_o(subaddr), .wr_data_o(wr_data));
	vsl_ctrl i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en),
		.rd_en_i(rd_en), .subaddr_i(subaddr), .wr_data_i(wr_data),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid), .detected_60hz_i(det60),
		.source_interlaced_i(inter), .field_start_i(fstart),
		.std_is_pal_i(pal), .field_60hz_o(), .lines_per_frame_o(),
		.field_parity_o(parity), .htc_mode_o(), .htc_reserved_o(),
		.horiz_loop_open_o(), .vnr_mode_o(), .vnr_fast_conflict_o(),
		.luma_path_o(), .extra_delay_lines_o(), .wide_notch_o(),
		.peaking_en_o(pk_en), .peaking_gain_o(gain), .lowpass_en_o(lp_en),
		.lowpass_level_o(lp_lvl), .lowpass_notch_o());
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic field_pulse(input logic flip);
		logic p;
		p = parity;
		fstart = 1'b1;
		@(posedge clock_i);
		#1;
		fstart = 1'b0;
		check(parity, p ^ flip);
	endtask
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	// run needs well under 1000 cycles
	initial begin
		#100000;
		failures++;
		give_verdict();
	end
	initial begin
		rst_n_i = 1'b0;
		{det60, inter, fstart, pal} = '0;
		repeat (12) @(posedge clock_i);
		#1;
		rst_n_i = 1'b1;
		i_host.rd(8'h08, r);
		check(r, 8'h98);
		i_host.rd(8'h0a, r);
		check(r, 8'h00);
		$display("reset values done");
		repeat (24) begin
			lfsr = lfsr_next(lfsr);
			d = lfsr[7:0];
			if (d[1:0] == 2'b01)
				d[7] = 1'b0;
			{det60, pal} = lfsr[9:8];
			i_host.wr(8'h08, d);
			i_host.wr(8'h09, lfsr[15:8]);
			i_host.wr(8'h0b, 8'hff);
			i_host.rd(8'h08, r);
			check(r, d);
			i_host.rd(8'h09, r);
			check(r, lfsr[15:8]);
		end
		$display("random readback done");
		for (int c = 0; c < 16; c++) begin
			i_host.wr(8'h09, c[7:0]);
			check(gain, c < 8 ? gains[c] : 7'h00);
			check({pk_en, lp_en, lp_lvl}, {c > 0 && c < 8, c > 7,
				c > 7 ? c[2:0] : 3'h0});
		end
		$display("sharpness codes done");
		// deliberate misuse corner, raises the flag once
		i_host.wr(8'h08, 8'h81);
		for (int f = 0; f < 4; f++) begin
			inter = f[0];
			i_host.wr(8'h08, {2'b00, f[1], 5'h18});
			field_pulse(f[0] | f[1]);
		end
		$display("parity toggling done");
		rst_n_i = 1'b0;
		@(posedge clock_i);
		#1;
		rst_n_i = 1'b1;
		i_host.rd(8'h09, r);
		check(r, 8'h00);
		$display("second reset done");
		give_verdict();
	end
endmodule // vsl_ctrl_bench
